//--- pkg/awd_defines.vh
// constants of the converter window detector: register map, fields, timing
// assumes inclusion by the top design file and the testbench of the detector
// What this block does
// - compare every finished result against limits
// - two 16-bit limits, high and low bytes
// - upper below lower: match strictly inside
// - upper above lower: match strictly outside
// - limit values alone choose inside or outside
// - single-ended results and limits are unsigned
// - differential results signed, signed compare
// - all-ones limit means minus one signed
// - compare result in its selected justification
// - match flag readable and raises interrupt
// - conversion lasts ten SAR clock periods
`ifndef AWD_DEFINES_VH
`define AWD_DEFINES_VH

// ==========================================================
// register byte offsets
`define AWD_OFS_CONTROL 8'h00
`define AWD_OFS_UPPER_HIGH 8'h04
`define AWD_OFS_UPPER_LOW 8'h08
`define AWD_OFS_LOWER_HIGH 8'h0C
`define AWD_OFS_LOWER_LOW 8'h10
`define AWD_OFS_RESULT_HIGH 8'h14
`define AWD_OFS_RESULT_LOW 8'h18
`define AWD_OFS_INT_STATUS 8'h1C
`define AWD_OFS_INT_MASK 8'h20

// ==========================================================
// converter_control fields
`define AWD_CTL_ENABLE 7
`define AWD_CTL_DIFF 6
`define AWD_CTL_DONE 5
`define AWD_CTL_BUSY 4
`define AWD_CTL_MATCH 1
`define AWD_CTL_LJST 0

// interrupt status and mask fields
`define AWD_INT_DONE 0
`define AWD_INT_MATCH 1
`define AWD_INT_WIDTH 2

// ==========================================================
// reset values
`define AWD_RST_BYTE 8'h00
`define AWD_RST_LIMIT 16'h0000
`define AWD_RST_WORD 32'h0000_0000
`define AWD_RST_INT 2'h0

// ==========================================================
// conversion timing
`define AWD_CONV_SAR_CLOCKS 4'hA
`define AWD_SAR_DIV_DEFAULT 4
`define AWD_CODE_WIDTH 10
`define AWD_PAD_WIDTH 6

`endif

//--- design/awd_window_compare.v
// window comparison of one justified result word against two limits
// assumes result and limits share justification and number format
`timescale 1ns/1ps
`default_nettype none

module awd_window_compare (
    input wire [15:0] result_in,
    input wire [15:0] upper_in,
    input wire [15:0] lower_in,
    input wire signed_in,
    output reg match_out
);

    // ==========================================================
    // ordering helper

    // flipping the sign bit maps two's complement order onto unsigned order
    function less_than;
        input [15:0] a;
        input [15:0] b;
        input sgn;
        begin
            less_than = ({a[15] ^ sgn, a[14:0]} < {b[15] ^ sgn, b[14:0]});
        end
    endfunction

    reg above_upper;
    reg below_lower;
    reg upper_below;

    // ==========================================================
    // decision
    always @* begin
        above_upper = less_than(upper_in, result_in, signed_in);
        below_lower = less_than(result_in, lower_in, signed_in);
        upper_below = less_than(upper_in, lower_in, signed_in);
        if (upper_below) begin
            match_out = above_upper & below_lower;
        end else begin
            match_out = less_than(result_in, lower_in, signed_in) | above_upper;
        end
    end

endmodule // awd_window_compare

`default_nettype wire

//--- design/awd_top.v
// converter window detector with APB register slave and conversion timer
// assumes a SAR core that holds sample_code_in steady at conversion end
// and an APB master on the same clock
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "awd_defines.vh"

module awd_top #(
    parameter SAR_DIV = `AWD_SAR_DIV_DEFAULT
) (
    input wire clock_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [9:0] sample_code_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    output reg busy_out,
    output reg sar_clock_out,
    output reg irq_out
);

    // ==========================================================
    // helpers

    // places the raw code in the 16-bit word as software sees it
    function [15:0] justify;
        input [9:0] code;
        input left;
        input diff;
        begin
            if (left) begin
                justify = {code, {`AWD_PAD_WIDTH{1'b0}}};
            end else if (diff) begin
                justify = {{`AWD_PAD_WIDTH{code[9]}}, code};
            end else begin
                justify = {{`AWD_PAD_WIDTH{1'b0}}, code};
            end
        end
    endfunction

    // ==========================================================
    // state
    reg enable_r;
    reg diff_r;
    reg ljst_r;
    reg done_flag_r;
    reg match_flag_r;
    reg [7:0] upper_high_r;
    reg [7:0] upper_low_r;
    reg [7:0] lower_high_r;
    reg [7:0] lower_low_r;
    reg [15:0] result_r;
    reg [`AWD_INT_WIDTH-1:0] int_status_r;
    reg [`AWD_INT_WIDTH-1:0] int_mask_r;
    reg [7:0] div_cnt_r;
    reg [3:0] sar_cnt_r;
    reg finish_r;

    wire access;
    wire commit_wr;
    wire start_req;
    wire sar_edge;
    wire conv_end;
    wire [15:0] fresh_word;
    wire window_hit;
    wire match_event;
    reg [31:0] rd_data;
    reg rd_err;

    // ==========================================================
    // apb handshake
    // the answer comes one cycle into the access phase, so the read mux
    // is registered and pready always stands for exactly one cycle
    assign access = psel_in & penable_in & ~pready_out;
    assign commit_wr = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= `AWD_RST_WORD;
        end else begin
            pready_out <= access;
            if (access) begin
                pslverr_out <= rd_err;
                prdata_out <= pwrite_in ? `AWD_RST_WORD : rd_data;
            end else begin
                pslverr_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read mux
    always @* begin
        rd_data = `AWD_RST_WORD;
        rd_err = 1'b0;
        case (paddr_in)
            `AWD_OFS_CONTROL: begin
                rd_data[`AWD_CTL_ENABLE] = enable_r;
                rd_data[`AWD_CTL_DIFF] = diff_r;
                rd_data[`AWD_CTL_DONE] = done_flag_r;
                rd_data[`AWD_CTL_BUSY] = busy_out;
                rd_data[`AWD_CTL_MATCH] = match_flag_r;
                rd_data[`AWD_CTL_LJST] = ljst_r;
            end
            `AWD_OFS_UPPER_HIGH: begin
                rd_data[7:0] = upper_high_r;
            end
            `AWD_OFS_UPPER_LOW: begin
                rd_data[7:0] = upper_low_r;
            end
            `AWD_OFS_LOWER_HIGH: begin
                rd_data[7:0] = lower_high_r;
            end
            `AWD_OFS_LOWER_LOW: begin
                rd_data[7:0] = lower_low_r;
            end
            `AWD_OFS_RESULT_HIGH: begin
                rd_data[7:0] = result_r[15:8];
            end
            `AWD_OFS_RESULT_LOW: begin
                rd_data[7:0] = result_r[7:0];
            end
            `AWD_OFS_INT_STATUS: begin
                rd_data[`AWD_INT_WIDTH-1:0] = int_status_r;
            end
            `AWD_OFS_INT_MASK: begin
                rd_data[`AWD_INT_WIDTH-1:0] = int_mask_r;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // control register

    // a one written to busy starts a conversion only if enable is already set; ignored while one runs
    assign start_req = commit_wr & (paddr_in == `AWD_OFS_CONTROL)
        & pwdata_in[`AWD_CTL_BUSY] & enable_r & ~busy_out;

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            enable_r <= 1'b0;
            diff_r <= 1'b0;
            ljst_r <= 1'b0;
        end else if (commit_wr && paddr_in == `AWD_OFS_CONTROL) begin
            enable_r <= pwdata_in[`AWD_CTL_ENABLE];
            diff_r <= pwdata_in[`AWD_CTL_DIFF];
            ljst_r <= pwdata_in[`AWD_CTL_LJST];
        end
    end

    // ==========================================================
    // limit registers
    // limit bytes
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            upper_high_r <= `AWD_RST_BYTE;
            upper_low_r <= `AWD_RST_BYTE;
            lower_high_r <= `AWD_RST_BYTE;
            lower_low_r <= `AWD_RST_BYTE;
        end else if (commit_wr) begin
            case (paddr_in)
                `AWD_OFS_UPPER_HIGH: begin
                    upper_high_r <= pwdata_in[7:0];
                end
                `AWD_OFS_UPPER_LOW: begin
                    upper_low_r <= pwdata_in[7:0];
                end
                `AWD_OFS_LOWER_HIGH: begin
                    lower_high_r <= pwdata_in[7:0];
                end
                `AWD_OFS_LOWER_LOW: begin
                    lower_low_r <= pwdata_in[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // conversion timer
    // the SAR clock is a divided system clock, so conversion length
    // scales with SAR_DIV; sar_edge marks each SAR period end
    assign sar_edge = busy_out && (div_cnt_r == SAR_DIV[7:0] - 8'h01);
    assign conv_end = sar_edge && (sar_cnt_r == `AWD_CONV_SAR_CLOCKS - 4'h1);

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            busy_out <= 1'b0;
            div_cnt_r <= 8'h00;
            sar_cnt_r <= 4'h0;
            sar_clock_out <= 1'b0;
            finish_r <= 1'b0;
        end else begin
            finish_r <= conv_end;
            if (start_req) begin
                busy_out <= 1'b1;
                div_cnt_r <= 8'h00;
                sar_cnt_r <= 4'h0;
                sar_clock_out <= 1'b0;
            end else if (busy_out) begin
                if (sar_edge) begin
                    div_cnt_r <= 8'h00;
                    sar_cnt_r <= sar_cnt_r + 4'h1;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
                sar_clock_out <= (div_cnt_r < SAR_DIV[7:0] / 8'h02) ? 1'b1 : 1'b0;
                if (conv_end || !enable_r) begin
                    busy_out <= 1'b0;
                    sar_clock_out <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // result capture and window check
    // justified compare
    assign fresh_word = justify(sample_code_in, ljst_r, diff_r);

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            result_r <= `AWD_RST_LIMIT;
        end else if (conv_end) begin
            result_r <= fresh_word;
        end
    end

    // compare the stored word one cycle later so that the comparator
    // sees exactly what software reads back
    awd_window_compare u_compare (
        .result_in(result_r),
        .upper_in({upper_high_r, upper_low_r}),
        .lower_in({lower_high_r, lower_low_r}),
        .signed_in(diff_r),
        .match_out(window_hit)
    );

    assign match_event = finish_r & window_hit;

    // ==========================================================
    // sticky flags in the control register
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            done_flag_r <= 1'b0;
            match_flag_r <= 1'b0;
        end else begin
            if (match_event) begin
                match_flag_r <= 1'b1;
            end else if (commit_wr && paddr_in == `AWD_OFS_CONTROL
                         && !pwdata_in[`AWD_CTL_MATCH]) begin
                match_flag_r <= 1'b0;
            end
            if (finish_r) begin
                done_flag_r <= 1'b1;
            end else if (commit_wr && paddr_in == `AWD_OFS_CONTROL
                         && !pwdata_in[`AWD_CTL_DONE]) begin
                done_flag_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // interrupt status, mask and output
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            int_status_r <= `AWD_RST_INT;
            int_mask_r <= `AWD_RST_INT;
        end else begin
            // events win over a write-one clear in the same cycle
            if (commit_wr && paddr_in == `AWD_OFS_INT_STATUS) begin
                int_status_r[`AWD_INT_DONE] <= finish_r
                    | (int_status_r[`AWD_INT_DONE] & ~pwdata_in[`AWD_INT_DONE]);
                int_status_r[`AWD_INT_MATCH] <= match_event
                    | (int_status_r[`AWD_INT_MATCH] & ~pwdata_in[`AWD_INT_MATCH]);
            end else begin
                int_status_r[`AWD_INT_DONE] <= int_status_r[`AWD_INT_DONE] | finish_r;
                int_status_r[`AWD_INT_MATCH] <= int_status_r[`AWD_INT_MATCH] | match_event;
            end
            if (commit_wr && paddr_in == `AWD_OFS_INT_MASK) begin
                int_mask_r <= pwdata_in[`AWD_INT_WIDTH-1:0];
            end
        end
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_status_r & int_mask_r);
        end
    end

endmodule // awd_top

`default_nettype wire

//--- testbench/awd_asserts.sv
// port-level checker of bus and conversion timing of the window detector
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module awd_asserts #(
    parameter SAR_DIV = 4
) (
    input wire clock_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire busy_out,
    input wire sar_clock_out
);
    localparam int CONV = 10 * SAR_DIV;
    int busy_n;
    int rise_n;
    // ==========================================================
    // helper counters, cleared whenever no conversion runs
    always @(posedge clock_in) begin
        busy_n <= (!nrst_in || !busy_out) ? 0 : busy_n + 1;
        rise_n <= (!nrst_in || !busy_out) ? 0 : rise_n + ($rose(sar_clock_out) ? 1 : 0);
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_commit;
        pready_out && pwrite_in && paddr_in == 8'h00 && pwdata_in[4];
    endsequence
    AST_ONE_WAIT: assert property (s_access |=> pready_out)
        else $error("ready not one cycle after access");
    AST_READY_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    AST_UNMAPPED_ERR: assert property (pready_out && paddr_in > 8'h20 |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (pready_out && paddr_in <= 8'h20 && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
        else $error("mapped access refused");
    AST_START_CAUSE: assert property ($rose(busy_out) |-> $past(pready_out) && $past(pwrite_in) && $past(pwdata_in[4]) && $past(paddr_in) == 8'h00)
        else $error("busy without start write");
    AST_CONV_LEN: assert property ($fell(busy_out) |-> busy_n == CONV)
        else $error("conversion length wrong");
    AST_SAR_COUNT: assert property ($fell(busy_out) |-> rise_n == 10)
        else $error("sar clock periods per conversion wrong");
    AST_SAR_IDLE: assert property ($changed(sar_clock_out) |-> busy_out || $past(busy_out))
        else $error("sar clock moves while idle");
    cover property (s_commit ##1 busy_out);
endmodule // awd_asserts
bind awd_top awd_asserts #(.SAR_DIV(SAR_DIV)) i_awd_asserts (.clock_in(clock_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .busy_out(busy_out), .sar_clock_out(sar_clock_out));
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench of the window detector, driven over its APB port
// assumes awd_top with a short SAR divider; the core side is the sample code input
`timescale 1ns/1ps
`default_nettype none
`include "awd_defines.vh"
module tb;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [9:0] sample_code_in = 10'h000;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, busy_out, sar_clock_out, irq_out;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] hi;
    awd_top #(.SAR_DIV(2)) i_awd_top (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .sample_code_in(sample_code_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .busy_out(busy_out), .sar_clock_out(sar_clock_out), .irq_out(irq_out));
    // ==========================================================
    // clock, timeout and verdict
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // ==========================================================
    // bus master: request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        // no assumed wait length: only the bench timeout ends this wait
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    function automatic logic [15:0] just(input logic [9:0] c, input logic lj, input logic df);
        if (lj) return {c, 6'h00};
        return df ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction
    // the enable write comes first because a start is honoured only once enabled
    task automatic conv(input logic [9:0] code, input logic [7:0] ctl);
        sample_code_in <= code;
        apb(1'b1, `AWD_OFS_CONTROL, {24'h0, ctl | 8'h80});
        apb(1'b1, `AWD_OFS_CONTROL, {24'h0, ctl | 8'h90});
        for (int i = 0; i < 100 && (i < 2 || busy_out === 1'b1); i++) @(posedge clock_in);
        repeat (3) @(posedge clock_in);
    endtask
    task automatic win(input logic [7:0] ctl, input logic [15:0] up, input logic [15:0] lo,
        input logic [9:0] code, input logic exp);
        apb(1'b1, `AWD_OFS_UPPER_HIGH, {24'h0, up[15:8]});
        apb(1'b1, `AWD_OFS_UPPER_LOW, {24'h0, up[7:0]});
        apb(1'b1, `AWD_OFS_LOWER_HIGH, {24'h0, lo[15:8]});
        apb(1'b1, `AWD_OFS_LOWER_LOW, {24'h0, lo[7:0]});
        conv(code, ctl);
        apb(1'b0, `AWD_OFS_RESULT_HIGH, 32'h0);
        hi = rd[7:0];
        apb(1'b0, `AWD_OFS_RESULT_LOW, 32'h0);
        chk({16'h0, hi, rd[7:0]}, {16'h0, just(code, ctl[0], ctl[6])}, "result");
        apb(1'b0, `AWD_OFS_CONTROL, 32'h0);
        chk({31'h0, rd[1]}, {31'h0, exp}, "match");
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd | {31'h0, err}, 32'h0, "reset");
        end
        apb(1'b1, 8'h24, 32'hFF);
        apb(1'b0, 8'h24, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        apb(1'b1, `AWD_OFS_RESULT_LOW, 32'hFF);
        apb(1'b0, `AWD_OFS_RESULT_LOW, 32'h0);
        chk(rd, 32'h0, "ro result");
    endtask
    task automatic t_refuse();
        apb(1'b1, `AWD_OFS_CONTROL, 32'h10);
        repeat (3) @(posedge clock_in);
        chk({31'h0, busy_out}, 32'h0, "start off");
    endtask
    task automatic t_limits();
        for (int a = 4; a <= 16; a += 4) begin
            apb(1'b1, 8'(a), 32'hA0 + a);
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, 32'hA0 + a, "limit");
        end
    endtask
    task automatic t_window();
        win(8'h00, 16'h0040, 16'h0080, 10'h041, 1'b1);
        win(8'h00, 16'h0040, 16'h0080, 10'h040, 1'b0);
        win(8'h00, 16'h0040, 16'h0080, 10'h080, 1'b0);
        win(8'h00, 16'h0080, 16'h0040, 10'h03F, 1'b1);
        win(8'h00, 16'h0080, 16'h0040, 10'h081, 1'b1);
        win(8'h00, 16'h0080, 16'h0040, 10'h060, 1'b0);
        win(8'h00, 16'h0100, 16'h03FF, 10'h200, 1'b1);
        win(8'h40, 16'hFFFF, 16'h0040, 10'h000, 1'b1);
        win(8'h40, 16'hFFFF, 16'h0040, 10'h3FF, 1'b0);
        win(8'h40, 16'h0040, 16'hFFFF, 10'h3FE, 1'b1);
        win(8'h01, 16'h1000, 16'h2000, 10'h041, 1'b1);
        win(8'h01, 16'h1000, 16'h2000, 10'h040, 1'b0);
        win(8'h41, 16'hFFC0, 16'h1000, 10'h000, 1'b1);
        win(8'h41, 16'hFFC0, 16'h1000, 10'h3FE, 1'b0);
    endtask
    task automatic t_sticky();
        win(8'h00, 16'h0040, 16'h0080, 10'h050, 1'b1);
        conv(10'h000, 8'h02);
        apb(1'b0, `AWD_OFS_CONTROL, 32'h0);
        chk({31'h0, rd[1]}, 32'h1, "sticky");
        apb(1'b1, `AWD_OFS_CONTROL, 32'h80);
        apb(1'b0, `AWD_OFS_CONTROL, 32'h0);
        chk({31'h0, rd[1]}, 32'h0, "cleared");
    endtask
    task automatic t_irq();
        apb(1'b1, `AWD_OFS_INT_STATUS, 32'h3);
        win(8'h00, 16'h0040, 16'h0080, 10'h050, 1'b1);
        chk({31'h0, irq_out}, 32'h0, "masked");
        apb(1'b0, `AWD_OFS_INT_STATUS, 32'h0);
        chk(rd, 32'h3, "status");
        apb(1'b1, `AWD_OFS_INT_MASK, 32'h2);
        repeat (3) @(posedge clock_in);
        chk({31'h0, irq_out}, 32'h1, "irq");
        apb(1'b1, `AWD_OFS_INT_STATUS, 32'h2);
        repeat (3) @(posedge clock_in);
        chk({31'h0, irq_out}, 32'h0, "irq clear");
        apb(1'b0, `AWD_OFS_INT_STATUS, 32'h0);
        chk(rd, 32'h1, "w1c");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_reset();
        t_refuse();
        t_limits();
        t_window();
        t_sticky();
        t_irq();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
